// ===== hw/rffe_regs_consts.svh
// Register offsets, field positions, reset values and widths of the slave
`ifndef RFFE_REGS_CONSTS_SVH
`define RFFE_REGS_CONSTS_SVH

`define OFS_RF_CONTROL 5'h00
`define OFS_GROUP_ID 5'h1B
`define OFS_POWER_AND_TRIGGER_CONTROL 5'h1C
`define OFS_PART_NUMBER_CODE 5'h1D
`define OFS_MAKER_CODE_LOW 5'h1E
`define OFS_MAKER_CODE_HIGH_AND_SLAVE_ID 5'h1F

`define POWER_STATE_MSB 7
`define POWER_STATE_LSB 6
`define MASK_MSB 5
`define MASK_LSB 3
`define MAKER_HIGH_MSB 5
`define MAKER_HIGH_LSB 4

`define RST_RF_CONTROL 8'h00
`define RST_GROUP_ID 4'h0
`define RST_POWER_STATE 2'h2
`define RST_MASKS 3'h0
`define RST_SLAVE_ID 4'hB
`define POWER_STATE_STARTUP 2'h1

`define CMD_REG_WRITE 3'h2
`define CMD_REG_READ 3'h3
`define BROADCAST_ID 4'h0
`define CMD_FRAME_LAST 4'hC
`define DATA_FRAME_LAST 4'h8

`endif

// ===== hw/rffe_regs_pkg.sv
// Types shared by the serial slave logic
`default_nettype none

package rffe_regs_pkg;

  typedef enum logic [2:0] {
    S_IDLE,
    S_CMD,
    S_WDATA,
    S_PARK,
    S_RDATA,
    S_RPARK
  } frame_state_type;

endpackage : rffe_regs_pkg

`default_nettype wire

// ===== hw/rffe_line_sampler.sv
// Synchroniser and edge finder for the serial clock and data lines
`timescale 1ns/1ps
`default_nettype none

module rffe_line_sampler (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic sdata_i,
  input wire logic driving_i,
  output logic sclk_rise_o,
  output logic sclk_fall_o,
  output logic sdata_o,
  output logic ssc_o
);

  logic sclk_meta_r;
  logic sclk_sync_r;
  logic sclk_last_r;
  logic sdata_meta_r;
  logic sdata_sync_r;
  logic sdata_last_r;

  // Both lines see the same two-stage delay, so their order is kept
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_meta_r <= 1'b0;
      sclk_sync_r <= 1'b0;
      sclk_last_r <= 1'b0;
      sdata_meta_r <= 1'b0;
      sdata_sync_r <= 1'b0;
      sdata_last_r <= 1'b0;
    end else begin
      sclk_meta_r <= sclk_i;
      sclk_sync_r <= sclk_meta_r;
      sclk_last_r <= sclk_sync_r;
      sdata_meta_r <= sdata_i;
      sdata_sync_r <= sdata_meta_r;
      sdata_last_r <= sdata_sync_r;
    end
  end

  assign sclk_rise_o = sclk_sync_r && !sclk_last_r;
  assign sclk_fall_o = !sclk_sync_r && sclk_last_r;
  assign sdata_o = sdata_sync_r;
  // Data only moves while the clock is low at a sequence start
  assign ssc_o = !sdata_sync_r && sdata_last_r && !sclk_sync_r &&
                 !sclk_last_r && !driving_i;

endmodule : rffe_line_sampler

`default_nettype wire

// ===== hw/rffe_trigger_regs.sv
// Serial control slave with trigger staging and identity registers
`timescale 1ns/1ps
`default_nettype none
`include "rffe_regs_consts.svh"

module rffe_trigger_regs #(
  parameter logic [7:0] PART_NUMBER = 8'hA5,  // Arbitrary value
  parameter logic [9:0] MAKER_CODE = 10'h123,  // Arbitrary value
  parameter int RF_TRIGGER = 0
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic sclk_i,
  input wire logic sdata_i,
  output logic sdata_o,
  output logic sdata_oe_n_o,
  output logic [7:0] rf_control_o,
  output logic [1:0] power_state_o
);

  logic rst_meta_r, rst_n;
  logic sclk_rise, sclk_fall, sdata_s, ssc;
  rffe_regs_pkg::frame_state_type state_r;
  logic [3:0] cnt_r;
  logic [12:0] shift_r;
  logic [4:0] addr_r;
  logic [12:0] frame;
  logic cmd_done, sa_match, wr_fire;
  logic [4:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] stage_r;
  logic [2:0] mask_r, mask_nxt;
  logic [3:0] group_id_r, slave_id_r;
  logic pm_reset;

  function automatic logic odd_ok(input logic [12:0] bits);
    odd_ok = ^bits;
  endfunction : odd_ok

  function automatic logic [7:0] reg_read(input logic [4:0] a,
      input logic [7:0] rf, input logic [1:0] pm, input logic [2:0] m,
      input logic [3:0] gid, input logic [3:0] sid);
    unique case (a)
      `OFS_RF_CONTROL: reg_read = rf;
      `OFS_GROUP_ID: reg_read = {4'h0, gid};
      `OFS_POWER_AND_TRIGGER_CONTROL: reg_read = {pm, m, 3'h0};
      `OFS_PART_NUMBER_CODE: reg_read = PART_NUMBER;
      `OFS_MAKER_CODE_LOW: reg_read = MAKER_CODE[7:0];
      `OFS_MAKER_CODE_HIGH_AND_SLAVE_ID:
        reg_read = {2'h0, MAKER_CODE[9:8], sid};
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // Lines are assumed quiet at power-up and during RF on
  rffe_line_sampler u_lines (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .sclk_i(sclk_i),
    .sdata_i(sdata_i),
    .driving_i(!sdata_oe_n_o),
    .sclk_rise_o(sclk_rise),
    .sclk_fall_o(sclk_fall),
    .sdata_o(sdata_s),
    .ssc_o(ssc)
  );

  assign frame = {shift_r[11:0], sdata_s};
  // Broadcast reaches only the power and trigger register
  assign sa_match = (frame[12:9] == slave_id_r) ||
      (frame[12:9] == `BROADCAST_ID && frame[8:6] == `CMD_REG_WRITE &&
       frame[5:1] == `OFS_POWER_AND_TRIGGER_CONTROL);
  assign cmd_done = sclk_fall && state_r == rffe_regs_pkg::S_CMD &&
      cnt_r == `CMD_FRAME_LAST && odd_ok(frame) && sa_match;
  assign wr_fire = (cmd_done && frame[8]) ||
      (sclk_fall && state_r == rffe_regs_pkg::S_WDATA &&
       cnt_r == `DATA_FRAME_LAST && odd_ok({4'h0, frame[8:0]}));
  assign wr_addr = (state_r == rffe_regs_pkg::S_CMD) ? `OFS_RF_CONTROL :
      addr_r;
  assign wr_data = (state_r == rffe_regs_pkg::S_CMD) ?
      {1'b0, frame[7:1]} : frame[8:1];
  assign mask_nxt = wr_data[`MASK_MSB:`MASK_LSB];
  assign pm_reset = wr_fire && wr_addr == `OFS_POWER_AND_TRIGGER_CONTROL &&
      wr_data[`POWER_STATE_MSB:`POWER_STATE_LSB] == `POWER_STATE_STARTUP;

  // Frame sequencer; a new start condition aborts any frame except while the slave drives the data line
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= rffe_regs_pkg::S_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 13'h0000;
      addr_r <= 5'h00;
    end else if (ssc) begin
      state_r <= rffe_regs_pkg::S_CMD;
      cnt_r <= 4'h0;
    end else if (sclk_fall) begin
      unique case (state_r)
        rffe_regs_pkg::S_IDLE: ;
        rffe_regs_pkg::S_CMD: begin
          shift_r <= frame;
          cnt_r <= cnt_r + 4'h1;
          addr_r <= frame[5:1];
          if (cnt_r == `CMD_FRAME_LAST) begin
            cnt_r <= 4'h0;
            if (!cmd_done || frame[8]) begin
              state_r <= rffe_regs_pkg::S_IDLE;
            end else if (frame[8:6] == `CMD_REG_WRITE) begin
              state_r <= rffe_regs_pkg::S_WDATA;
            end else if (frame[8:6] == `CMD_REG_READ &&
                         frame[12:9] == slave_id_r) begin
              state_r <= rffe_regs_pkg::S_PARK;
            end else begin
              state_r <= rffe_regs_pkg::S_IDLE;
            end
          end
        end
        rffe_regs_pkg::S_WDATA: begin
          shift_r <= frame;
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == `DATA_FRAME_LAST) begin
            state_r <= rffe_regs_pkg::S_IDLE;
          end
        end
        rffe_regs_pkg::S_PARK: begin
          shift_r <= {4'h0, reg_read(addr_r, rf_control_o, power_state_o,
              mask_r, group_id_r, slave_id_r), ~^reg_read(addr_r,
              rf_control_o, power_state_o, mask_r, group_id_r, slave_id_r)};
          state_r <= rffe_regs_pkg::S_RDATA;
        end
        rffe_regs_pkg::S_RDATA: begin
          shift_r <= {shift_r[11:0], 1'b0};
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == `DATA_FRAME_LAST) begin
            state_r <= rffe_regs_pkg::S_RPARK;
          end
        end
        rffe_regs_pkg::S_RPARK: state_r <= rffe_regs_pkg::S_IDLE;
        default: state_r <= rffe_regs_pkg::S_IDLE;
      endcase
    end
  end

  // Read data is launched on the clock's rising edge, master samples falling
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      sdata_o <= 1'b0;
      sdata_oe_n_o <= 1'b1;
    end else if (ssc || state_r == rffe_regs_pkg::S_IDLE) begin
      sdata_o <= 1'b0;
      sdata_oe_n_o <= 1'b1;
    end else if (sclk_rise && state_r == rffe_regs_pkg::S_RDATA) begin
      sdata_o <= shift_r[8];
      sdata_oe_n_o <= 1'b0;
    end else if (sclk_rise && state_r == rffe_regs_pkg::S_RPARK) begin
      sdata_o <= 1'b0;
      sdata_oe_n_o <= 1'b0;
    end else if (sclk_fall && state_r == rffe_regs_pkg::S_RPARK) begin
      sdata_oe_n_o <= 1'b1;
    end
  end

  // Power state, masks and the trigger action
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      power_state_o <= `RST_POWER_STATE;
      mask_r <= `RST_MASKS;
      rf_control_o <= `RST_RF_CONTROL;
      stage_r <= `RST_RF_CONTROL;
    end else if (pm_reset) begin
      power_state_o <= `RST_POWER_STATE;
      mask_r <= `RST_MASKS;
      rf_control_o <= `RST_RF_CONTROL;
      stage_r <= `RST_RF_CONTROL;
    end else if (wr_fire && wr_addr == `OFS_POWER_AND_TRIGGER_CONTROL) begin
      power_state_o <= wr_data[`POWER_STATE_MSB:`POWER_STATE_LSB];
      mask_r <= mask_nxt;
      // Trigger bits are never stored, only acted on
      if (wr_data[RF_TRIGGER] && !mask_nxt[RF_TRIGGER]) begin
        rf_control_o <= stage_r;
      end
    end else if (wr_fire && wr_addr == `OFS_RF_CONTROL) begin
      if (&mask_r) begin
        rf_control_o <= wr_data;
      end else begin
        stage_r <= wr_data;
      end
    end
  end

  // Identifier registers; the maker bits in 0x1F are constants
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      group_id_r <= `RST_GROUP_ID;
      slave_id_r <= `RST_SLAVE_ID;
    end else if (pm_reset) begin
      group_id_r <= `RST_GROUP_ID;
      slave_id_r <= `RST_SLAVE_ID;
    end else if (wr_fire && wr_addr == `OFS_GROUP_ID) begin
      group_id_r <= wr_data[3:0];
    end else if (wr_fire && wr_addr == `OFS_MAKER_CODE_HIGH_AND_SLAVE_ID) begin
      slave_id_r <= wr_data[3:0];
    end
  end

  property p_mask_store;
    @(posedge mclk_i) disable iff (!rst_n)
    (wr_fire && wr_addr == `OFS_POWER_AND_TRIGGER_CONTROL && !pm_reset)
      |=> mask_r == $past(mask_nxt);
  endproperty
  a_mask_store: assert property (p_mask_store)
    else $error("mask bits not stored from write");

  property p_direct;
    @(posedge mclk_i) disable iff (!rst_n)
    (wr_fire && wr_addr == `OFS_RF_CONTROL && &mask_r)
      |=> rf_control_o == $past(wr_data) && $stable(stage_r);
  endproperty
  a_direct: assert property (p_direct)
    else $error("write with all masks set did not land directly");

  property p_trigger;
    @(posedge mclk_i) disable iff (!rst_n)
    (wr_fire && wr_addr == `OFS_POWER_AND_TRIGGER_CONTROL && !pm_reset &&
     wr_data[RF_TRIGGER] && !mask_nxt[RF_TRIGGER])
      |=> rf_control_o == $past(stage_r);
  endproperty
  a_trigger: assert property (p_trigger)
    else $error("trigger did not move staged value");

  property p_trig_read_zero;
    @(posedge mclk_i) disable iff (!rst_n)
    (sclk_fall && state_r == rffe_regs_pkg::S_PARK &&
     addr_r == `OFS_POWER_AND_TRIGGER_CONTROL) |=> shift_r[3:1] == 3'h0;
  endproperty
  a_trig_read_zero: assert property (p_trig_read_zero)
    else $error("trigger bits read back nonzero");

  property p_maker_low;
    @(posedge mclk_i) disable iff (!rst_n)
    (sclk_fall && state_r == rffe_regs_pkg::S_PARK &&
     addr_r == `OFS_MAKER_CODE_LOW) |=> shift_r[8:1] == MAKER_CODE[7:0];
  endproperty
  a_maker_low: assert property (p_maker_low)
    else $error("maker code low byte wrong");

  property p_maker_high;
    @(posedge mclk_i) disable iff (!rst_n)
    (sclk_fall && state_r == rffe_regs_pkg::S_PARK &&
     addr_r == `OFS_MAKER_CODE_HIGH_AND_SLAVE_ID) |=>
      shift_r[8:5] == {2'h0, MAKER_CODE[9:8]};
  endproperty
  a_maker_high: assert property (p_maker_high)
    else $error("maker code high bits read back wrong");

  property p_pm_reset;
    @(posedge mclk_i) disable iff (!rst_n)
    pm_reset |=> rf_control_o == `RST_RF_CONTROL &&
      slave_id_r == `RST_SLAVE_ID && mask_r == `RST_MASKS &&
      power_state_o == `RST_POWER_STATE;
  endproperty
  a_pm_reset: assert property (p_pm_reset)
    else $error("startup write did not restore defaults");

  property p_masked_trigger;
    @(posedge mclk_i) disable iff (!rst_n)
    (wr_fire && wr_addr == `OFS_POWER_AND_TRIGGER_CONTROL && !pm_reset &&
     wr_data[RF_TRIGGER] && mask_nxt[RF_TRIGGER])
      |=> $stable(rf_control_o) && $stable(stage_r);
  endproperty
  a_masked_trigger: assert property (p_masked_trigger)
    else $error("masked trigger moved staged value");

endmodule : rffe_trigger_regs

`default_nettype wire

// ===== testbench/rffe_master_model.sv
// Behavioural serial bus master driving the slave's clock and data lines
`timescale 1ns/1ps
`default_nettype none

module rffe_master_model (
  output logic sclk_o,
  output logic sdata_o,
  output logic sdata_en_o,
  output logic rf_on_o,
  input wire logic sdata_wire_i
);
  initial begin
    sclk_o = 1'b0;
    sdata_o = 1'b0;
    sdata_en_o = 1'b0;
    rf_on_o = 1'b0;
  end

  task automatic power_up();
    #10us;
  endtask : power_up

  // Clock stands low between frames; data changes on clock rise, except in the start sequence
  task automatic send_bit(input logic b);
    sclk_o = 1'b1;
    sdata_o = b;
    #160;
    sclk_o = 1'b0;
    #160;
  endtask : send_bit

  task automatic recv_bit(output logic b);
    sclk_o = 1'b1;
    #160;
    b = sdata_wire_i;
    sclk_o = 1'b0;
    #160;
  endtask : recv_bit

  task automatic send_cmd(input logic [11:0] c);
    sdata_en_o = 1'b1;
    sdata_o = 1'b1;
    #160;
    sdata_o = 1'b0;
    #160;
    for (int i = 11; i >= 0; i--) send_bit(c[i]);
    send_bit(~^c);
  endtask : send_cmd

  // Park: drive low for one clock, release the line at the fall
  task automatic park();
    sclk_o = 1'b1;
    sdata_o = 1'b0;
    #160;
    sclk_o = 1'b0;
    sdata_en_o = 1'b0;
    #160;
  endtask : park

  task automatic reg_write(input logic [3:0] sa, input logic [4:0] a,
                           input logic [7:0] d);
    send_cmd({sa, 3'b010, a});
    for (int i = 7; i >= 0; i--) send_bit(d[i]);
    send_bit(~^d);
    park();
  endtask : reg_write

  task automatic reg0_write(input logic [3:0] sa, input logic [6:0] d);
    send_cmd({sa, 1'b1, d});
    park();
  endtask : reg0_write

  task automatic reg_read(input logic [3:0] sa, input logic [4:0] a,
                          output logic [7:0] d, output logic p,
                          output logic pk);
    send_cmd({sa, 3'b011, a});
    park();
    for (int i = 7; i >= 0; i--) recv_bit(d[i]);
    recv_bit(p);
    recv_bit(pk);
  endtask : reg_read

  // RF only after the bus idles, and removed before the lines go away
  task automatic rf_cycle();
    #2us;
    rf_on_o = 1'b1;
    #1us;
    rf_on_o = 1'b0;
    sdata_en_o = 1'b0;
  endtask : rf_cycle
endmodule : rffe_master_model
`default_nettype wire

// ===== testbench/rffe_trigger_and_id_registers_test.sv
// Self-checking bench for the trigger and identity register slave
`timescale 1ns/1ps
`default_nettype none

module rffe_trigger_and_id_registers_test;
  localparam logic [7:0] PART = 8'h3C; // Arbitrary value
  localparam logic [9:0] MAKER = 10'h2A7; // Arbitrary value
  logic mclk, resetn, sclk, sdata_m, sdata_en, rf_on, flt;
  logic s_o, oe_n;
  logic [7:0] rf_ctl;
  logic [1:0] pm;
  wire logic sdata_w;
  logic [3:0] sid;
  int n_fail, compares;

  // A released line shows the inverse of its last driven low level
  assign sdata_w = !oe_n ? s_o : (sdata_en ? sdata_m : flt);
  // The time-zero edge of the enable is not a release
  always @(negedge sdata_en) begin
    if ($time > 0) flt = ~sdata_m;
  end
  always @(posedge oe_n) flt = 1'b1;

  // Any movement of the clock or the master's data while the RF signal is on is a fault
  always @(sclk or sdata_m) begin
    if (rf_on) chk("bus moved with rf on", 8'h01, 8'h00);
  end

  rffe_trigger_regs #(.PART_NUMBER(PART), .MAKER_CODE(MAKER),
    .RF_TRIGGER(0)) DUT (.mclk_i(mclk), .resetn_i(resetn),
    .sclk_i(sclk), .sdata_i(sdata_w), .sdata_o(s_o),
    .sdata_oe_n_o(oe_n), .rf_control_o(rf_ctl), .power_state_o(pm));

  rffe_master_model u_master (.sclk_o(sclk), .sdata_o(sdata_m),
    .sdata_en_o(sdata_en), .rf_on_o(rf_on), .sdata_wire_i(sdata_w));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    u_master.reg_write(sid, a, d);
  endtask : wr

  task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic p;
    logic pk;
    u_master.reg_read(sid, a, d, p, pk);
    chk("read data", d, exp);
    chk("read parity", {7'h00, ^{d, p}}, 8'h01);
    chk("bus park level", {7'h00, pk}, 8'h00);
    chk("line released", {7'h00, oe_n}, 8'h01);
  endtask : rdc

  initial begin
    repeat (60000) @(posedge mclk);
    n_fail++;
    $display("ERROR run limit reached");
    finish_test();
  end

  initial begin
    resetn = 1'b0;
    flt = 1'b1;
    sid = 4'hB;
    n_fail = 0;
    compares = 0;
    repeat (8) @(posedge mclk);
    #1 resetn = 1'b1;
    u_master.power_up();
    chk("rf control", rf_ctl, 8'h00);
    chk("power state", {6'h00, pm}, 8'h02);
    rdc(5'h1C, 8'h80);
    rdc(5'h1D, PART);
    rdc(5'h1E, MAKER[7:0]);
    rdc(5'h1F, {2'b00, MAKER[9:8], 4'hB});
    $display("test reset values done");
    wr(5'h1E, 8'h00);
    rdc(5'h1E, MAKER[7:0]);
    wr(5'h1F, 8'hFF);
    sid = 4'hF;
    rdc(5'h1F, {2'b00, MAKER[9:8], 4'hF});
    wr(5'h1F, 8'h0B);
    sid = 4'hB;
    wr(5'h1B, 8'h09);
    rdc(5'h1B, 8'h09);
    u_master.reg_write(4'h0, 5'h1B, 8'h03);
    rdc(5'h1B, 8'h09);
    rdc(5'h05, 8'h00);
    $display("test identity done");
    wr(5'h1C, 8'h00);
    wr(5'h00, 8'h07);
    chk("rf control", rf_ctl, 8'h00);
    wr(5'h1C, 8'h01);
    chk("rf control", rf_ctl, 8'h07);
    rdc(5'h1C, 8'h00);
    wr(5'h00, 8'h0C);
    wr(5'h1C, 8'h06);
    chk("rf control", rf_ctl, 8'h07);
    rdc(5'h1C, 8'h00);
    $display("test triggers done");
    wr(5'h1C, 8'h09);
    chk("rf control", rf_ctl, 8'h07);
    wr(5'h1C, 8'h31);
    chk("rf control", rf_ctl, 8'h0C);
    rdc(5'h1C, 8'h30);
    $display("test masks done");
    wr(5'h1C, 8'h38);
    wr(5'h00, 8'h04);
    chk("rf control", rf_ctl, 8'h04);
    u_master.reg0_write(sid, 7'h06);
    chk("rf control", rf_ctl, 8'h06);
    wr(5'h1C, 8'h3F);
    chk("rf control", rf_ctl, 8'h06);
    rdc(5'h1C, 8'h38);
    $display("test direct writes done");
    wr(5'h1C, 8'h00);
    chk("power state", {6'h00, pm}, 8'h00);
    wr(5'h1F, 8'h05);
    sid = 4'h5;
    u_master.reg_write(4'h0, 5'h1C, 8'h40);
    sid = 4'hB;
    chk("rf control", rf_ctl, 8'h00);
    chk("power state", {6'h00, pm}, 8'h02);
    rdc(5'h1C, 8'h80);
    rdc(5'h1F, {2'b00, MAKER[9:8], 4'hB});
    rdc(5'h1B, 8'h00);
    $display("test power state reset done");
    u_master.rf_cycle();
    finish_test();
  end
endmodule : rffe_trigger_and_id_registers_test
`default_nettype wire
